// ---- inc/i2c_status_pkg.sv ----
// Shared offsets, bit positions and codes for the two-wire status block.
// Assumes a 32-bit AXI4-Lite register bus; all offsets are byte addresses.
package i2c_status_pkg;
   localparam logic [7:0] OFF_RAW_STATUS  = 8'h30;
   localparam logic [7:0] OFF_MASKED      = 8'h34;
   localparam logic [7:0] OFF_MASK        = 8'h38;
   localparam logic [7:0] OFF_CLEAR       = 8'h3c;
   localparam logic [7:0] OFF_MASTER_CMD  = 8'h40;
   localparam logic [7:0] OFF_TRANS_STAT  = 8'h44;
   localparam int BIT_MASTER_DONE         = 19;
   localparam int BIT_ARB_LOST            = 24;
   localparam int BIT_BUS_ERROR           = 25;
   localparam int BIT_DONE_NO_STOP        = 28;
   localparam int BIT_CMD_STOP            = 0;
   localparam int BIT_CMD_READ            = 1;
   localparam logic [31:0] STATUS_USED    = 32'h1308_0000;
   localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
   localparam logic [3:0] TAG_NONE        = 4'h0;
   localparam logic [3:0] TAG_ARB_LOST    = 4'h1;
   localparam logic [3:0] TAG_BUS_ERROR   = 4'h2;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   typedef enum logic [3:0]
   {
      ST_IDLE    = 4'h1,
      ST_ACTIVE  = 4'h2,
      ST_HELD    = 4'h4,
      ST_WAITSTP = 4'h8
   } master_state_t;
endpackage

// ---- design/sticky_flag.sv ----
// One sticky status bit: hardware set wins over software clear.
// Assumes single clock, active-low asynchronous reset.
`timescale 1ns/1ns
module sticky_flag
(
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   // Control
   input  wire logic i_set,
   input  wire logic i_clr,
   // State
   output logic      o_flag
);
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         o_flag <= 1'b0;
      else if (i_set)
         o_flag <= 1'b1;
      else if (i_clr)
         o_flag <= 1'b0;
   end

   a_set_wins: assert property (@(posedge i_clk_sys)
      disable iff (!i_rstn) i_set |=> o_flag)
      else $error("sticky set lost");
endmodule

// ---- design/i2c_status.sv ----
// Interrupt status, error and held-bus logic of a two-wire bus controller.
// Assumes bus condition events arrive synchronous to i_clk_sys as pulses
// from the line engine; AXI4-Lite slave, one transaction per channel.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module i2c_status
   import i2c_status_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   // AXI4-Lite write
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Line engine events
   input  wire logic        i_start_seen,
   input  wire logic        i_stop_seen,
   input  wire logic        i_xfer_end,
   input  wire logic        i_arb_lost,
   input  wire logic        i_slave_wr_req,
   input  wire logic        i_slave_rd_req,
   // Line engine control
   output logic             o_xfer_go,
   output logic             o_xfer_read,
   output logic             o_send_stop,
   output logic             o_scl_hold_low,
   output logic             o_abort_master,
   output logic             o_slave_wr_req,
   output logic             o_slave_rd_req,
   // Interrupt
   output logic             o_irq
);
   master_state_t state_reg;
   logic [31:0]   mask_reg;
   logic [31:0]   cmd_reg;
   logic [3:0]    tag_reg;
   logic          retry_reg;
   logic [7:0]    aw_addr_reg;
   logic          aw_full_reg;
   logic [31:0]   w_data_reg;
   logic [3:0]    w_strb_reg;
   logic          w_full_reg;
   logic          wr_fire;
   logic [31:0]   clr_bits;
   logic [31:0]   raw_status;
   logic          set_bus_error_flag;
   logic          set_nostop;
   logic          set_done;
   logic          set_arb;
   logic          f_done;
   logic          f_arb;
   logic          f_bus_error_flag;
   logic          f_nostop;
   logic          cmd_write;
   logic          in_xfer;
   default clocking sys_edge @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);

   assign in_xfer = (state_reg == ST_ACTIVE);

   // Write channel: address and data taken in either order
   assign o_awready = !aw_full_reg && !o_bvalid;
   assign o_wready  = !w_full_reg && !o_bvalid;
   assign wr_fire   = aw_full_reg && w_full_reg && !o_bvalid;

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end
      else if (i_awvalid && o_awready)
      begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= i_awaddr;
      end
      else if (wr_fire)
         aw_full_reg <= 1'b0;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         w_full_reg <= 1'b0;
         w_data_reg <= RESET_ZERO;
         w_strb_reg <= 4'h0;
      end
      else if (i_wvalid && o_wready)
      begin
         w_full_reg <= 1'b1;
         w_data_reg <= i_wdata;
         w_strb_reg <= i_wstrb;
      end
      else if (wr_fire)
         w_full_reg <= 1'b0;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         o_bvalid <= 1'b1;
         o_bresp  <= (aw_addr_reg == OFF_MASK || aw_addr_reg == OFF_CLEAR
                      || aw_addr_reg == OFF_MASTER_CMD) ? RESP_OKAY
                                                        : RESP_SLVERR;
      end
      else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // Clear register: only fully strobed bytes count
   always_comb
   begin
      clr_bits = RESET_ZERO;
      if (wr_fire && aw_addr_reg == OFF_CLEAR)
         for (int b = 0; b < 4; b++)
            if (w_strb_reg[b])
               clr_bits[b*8 +: 8] = w_data_reg[b*8 +: 8];
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         mask_reg <= RESET_ZERO;
      else if (wr_fire && aw_addr_reg == OFF_MASK)
         for (int b = 0; b < 4; b++)
            if (w_strb_reg[b])
               mask_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8]
                                     & STATUS_USED[b*8 +: 8];
   end

   // Commands are ignored while any completion flag awaits acknowledgment
   assign cmd_write = wr_fire && aw_addr_reg == OFF_MASTER_CMD
                      && state_reg == ST_IDLE
                      && !f_nostop && !f_done;

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         cmd_reg <= RESET_ZERO;
      else if (cmd_write)
         cmd_reg <= w_data_reg;
   end

   // Event sources
   assign set_bus_error_flag   = in_xfer && (i_start_seen || i_stop_seen);
   assign set_arb    = in_xfer && i_arb_lost;
   assign set_done   = in_xfer && i_xfer_end && cmd_reg[BIT_CMD_STOP];
   assign set_nostop = in_xfer && i_xfer_end && !cmd_reg[BIT_CMD_STOP];
   sticky_flag u_done (.i_clk_sys (i_clk_sys), .i_rstn (i_rstn),
      .i_set (set_done), .i_clr (clr_bits[BIT_MASTER_DONE]),
      .o_flag (f_done));
   sticky_flag u_arb (.i_clk_sys (i_clk_sys), .i_rstn (i_rstn),
      .i_set (set_arb), .i_clr (clr_bits[BIT_ARB_LOST]),
      .o_flag (f_arb));
   sticky_flag u_bus_error_flag (.i_clk_sys (i_clk_sys), .i_rstn (i_rstn),
      .i_set (set_bus_error_flag), .i_clr (clr_bits[BIT_BUS_ERROR]),
      .o_flag (f_bus_error_flag));
   sticky_flag u_nostop (.i_clk_sys (i_clk_sys), .i_rstn (i_rstn),
      .i_set (set_nostop), .i_clr (clr_bits[BIT_DONE_NO_STOP]),
      .o_flag (f_nostop));

   always_comb
   begin
      raw_status = RESET_ZERO;
      raw_status[BIT_MASTER_DONE]  = f_done;
      raw_status[BIT_ARB_LOST]     = f_arb;
      raw_status[BIT_BUS_ERROR]    = f_bus_error_flag;
      raw_status[BIT_DONE_NO_STOP] = f_nostop;
   end

   assign o_irq = |(raw_status & mask_reg);

   // Error tag: last error_tag_a wins, cleared on a new command
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         tag_reg <= TAG_NONE;
      else if (set_bus_error_flag)
         tag_reg <= TAG_BUS_ERROR;
      else if (set_arb)
         tag_reg <= TAG_ARB_LOST;
      else if (cmd_write)
         tag_reg <= TAG_NONE;
   end

   // Master sequencer
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_reg <= ST_IDLE;
         retry_reg <= 1'b0;
      end
      else
         case (state_reg)
            ST_IDLE:
               if (cmd_write)
                  state_reg <= ST_ACTIVE;
            ST_ACTIVE:
               if (set_bus_error_flag)
                  state_reg <= ST_IDLE;
               else if (set_arb)
               begin
                  state_reg <= ST_WAITSTP;
                  retry_reg <= 1'b1;
               end
               else if (set_nostop)
                  state_reg <= ST_HELD;
               else if (i_xfer_end)
                  state_reg <= ST_IDLE;
            ST_HELD:
               if (!f_nostop)
                  state_reg <= ST_IDLE;
            ST_WAITSTP:
               if (i_stop_seen)
               begin
                  state_reg <= ST_ACTIVE;
                  retry_reg <= 1'b0;
               end
            default:
               state_reg <= ST_IDLE;
         endcase
   end

   assign o_xfer_go      = in_xfer;
   assign o_xfer_read    = cmd_reg[BIT_CMD_READ];
   assign o_send_stop    = in_xfer && cmd_reg[BIT_CMD_STOP];
   assign o_abort_master = (state_reg == ST_WAITSTP);
   assign o_scl_hold_low = f_nostop;
   assign o_slave_wr_req = i_slave_wr_req && !f_nostop;
   assign o_slave_rd_req = i_slave_rd_req && !f_nostop;

   // Read channel, one-cycle answer
   assign o_arready = !o_rvalid;

   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_rvalid <= 1'b0;
         o_rdata  <= RESET_ZERO;
         o_rresp  <= RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp  <= RESP_OKAY;
         case (i_araddr)
            OFF_RAW_STATUS: o_rdata <= raw_status;
            OFF_MASKED:     o_rdata <= raw_status & mask_reg;
            OFF_MASK:       o_rdata <= mask_reg;
            OFF_CLEAR:      o_rdata <= RESET_ZERO;
            OFF_MASTER_CMD: o_rdata <= cmd_reg;
            OFF_TRANS_STAT: o_rdata <= {26'h0, retry_reg, 1'b0, tag_reg};
            default:
            begin
               o_rdata <= RESET_ZERO;
               o_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (i_rready)
         o_rvalid <= 1'b0;
   end
   a_bus_error_flag_sets: assert property (
      in_xfer && i_stop_seen |=> raw_status[BIT_BUS_ERROR])
      else $error("bus error not flagged");
   a_bus_error_flag_tag: assert property (
      set_bus_error_flag |=> tag_reg == TAG_BUS_ERROR && state_reg == ST_IDLE)
      else $error("bus error tag missing");
   a_clear_drop: assert property (
      clr_bits[BIT_DONE_NO_STOP] && !set_nostop |=> !f_nostop)
      else $error("no-stop flag not cleared");
   a_nostop_sets: assert property (
      in_xfer && i_xfer_end && !cmd_reg[BIT_CMD_STOP] |=> f_nostop)
      else $error("no-stop flag not set");
   a_slave_hidden: assert property (
      f_nostop |-> !o_slave_wr_req && !o_slave_rd_req && o_scl_hold_low)
      else $error("slave request passed while held");
   a_no_stop_out: assert property (
      set_nostop && !set_bus_error_flag && !set_arb
      |=> state_reg == ST_HELD && !o_send_stop)
      else $error("stop issued without request");
   a_done_sets: assert property (
      set_done |=> f_done && !f_nostop ##1 f_done)
      else $error("done flag not set");
   a_arb_retry: assert property (
      set_arb && !set_bus_error_flag |=> f_arb && o_abort_master)
      else $error("arbitration loss not handled");
   a_reserved_zero: assert property (
      (raw_status & ~STATUS_USED) == RESET_ZERO
      && o_irq == |(raw_status & mask_reg))
      else $error("reserved status bit set");
   a_cmd_blocked: assert property (
      f_nostop && wr_fire |=> state_reg != ST_ACTIVE)
      else $error("command accepted while held");
   c_nostop: cover property (set_nostop);
   c_bus_error_flag: cover property (set_bus_error_flag);
   c_arb_retry: cover property (o_abort_master ##1 in_xfer);
   c_irq: cover property ($rose(o_irq));
endmodule

// ---- sim/bus_station_model.sv ----
// Behavioural stand-in for the line engine and the far-side stations.
// Assumes the bench drives injection pulses one clock wide.
`timescale 1ns/1ns
module bus_station_model
(
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rstn,
   // Bench control
   input  wire logic [3:0] i_delay,
   input  wire logic       i_inject_start,
   input  wire logic       i_inject_stop,
   input  wire logic       i_inject_arb,
   input  wire logic       i_slave_wr,
   input  wire logic       i_slave_rd,
   // From block
   input  wire logic       i_xfer_go,
   // To block
   output logic            o_start_seen,
   output logic            o_stop_seen,
   output logic            o_xfer_end,
   output logic            o_arb_lost,
   output logic            o_slave_wr_req,
   output logic            o_slave_rd_req
);
   logic       go_reg;
   logic [3:0] cnt_reg;

   assign o_start_seen   = i_inject_start;
   assign o_stop_seen    = i_inject_stop;
   assign o_arb_lost     = i_inject_arb;
   assign o_slave_wr_req = i_slave_wr;
   assign o_slave_rd_req = i_slave_rd;

   // Zero delay: the transfer never ends by itself, so a bus fault can hit
   // it; an aborted transfer cancels the pending end
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         go_reg     <= 1'b0;
         cnt_reg    <= 4'h0;
         o_xfer_end <= 1'b0;
      end
      else
      begin
         go_reg     <= i_xfer_go;
         o_xfer_end <= (cnt_reg == 4'h1) && i_xfer_go;
         if (!i_xfer_go)
            cnt_reg <= 4'h0;
         else if (!go_reg)
            cnt_reg <= i_delay;
         else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule

// ---- sim/i2c_status_bench.sv ----
// Self-checking bench for the two-wire status block over AXI4-Lite.
// Assumes the package offsets and a line engine model on the far side.
`timescale 1ns/1ns
module i2c_status_bench
   import i2c_status_pkg::*;
;
   logic        i_clk_sys = 1'b0;
   logic        i_rstn    = 1'b0;
   logic [7:0]  i_awaddr  = 8'h00;
   logic [7:0]  i_araddr  = 8'h00;
   logic [31:0] i_wdata   = 32'h0;
   logic [3:0]  i_wstrb   = 4'h0;
   logic [3:0]  dly       = 4'h0;
   logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0;
   logic        inj_start = 1'b0, inj_stop = 1'b0, inj_arb = 1'b0;
   logic        slv_wr    = 1'b0, slv_rd = 1'b0;
   logic        i_start_seen, i_stop_seen, i_xfer_end, i_arb_lost;
   logic        i_slave_wr_req, i_slave_rd_req;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]  o_bresp, o_rresp, rsp;
   logic [31:0] o_rdata, rd;
   logic        o_xfer_go, o_xfer_read, o_send_stop, o_scl_hold_low;
   logic        o_abort_master, o_slave_wr_req, o_slave_rd_req, o_irq;
   int          n_fail = 0, total_checks = 0, cycles = 0;

   i2c_status u_i2c_status (.i_clk_sys, .i_rstn, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
      .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
      .o_rresp, .o_rvalid, .i_rready, .i_start_seen, .i_stop_seen,
      .i_xfer_end, .i_arb_lost, .i_slave_wr_req, .i_slave_rd_req,
      .o_xfer_go, .o_xfer_read, .o_send_stop, .o_scl_hold_low,
      .o_abort_master, .o_slave_wr_req, .o_slave_rd_req, .o_irq);

   bus_station_model u_bus_station_model (.i_clk_sys, .i_rstn,
      .i_delay(dly), .i_inject_start(inj_start), .i_inject_stop(inj_stop),
      .i_inject_arb(inj_arb), .i_slave_wr(slv_wr), .i_slave_rd(slv_rd),
      .i_xfer_go(o_xfer_go), .o_start_seen(i_start_seen),
      .o_stop_seen(i_stop_seen), .o_xfer_end(i_xfer_end),
      .o_arb_lost(i_arb_lost), .o_slave_wr_req(i_slave_wr_req),
      .o_slave_rd_req(i_slave_rd_req));

   initial
   begin
      forever #50 i_clk_sys = ~i_clk_sys;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data offered together; each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_wstrb   <= 4'hf;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_bready  <= 1'b1;
      do
      begin
         @(posedge i_clk_sys);
         if (o_awready)
            i_awvalid <= 1'b0;
         if (o_wready)
            i_wvalid <= 1'b0;
      end
      while (o_bvalid !== 1'b1);
      rsp = o_bresp;
      i_bready <= 1'b0;
   endtask

   task rd_reg(input logic [7:0] a);
      @(posedge i_clk_sys);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      i_rready  <= 1'b1;
      do
      begin
         @(posedge i_clk_sys);
         if (o_arready)
            i_arvalid <= 1'b0;
      end
      while (o_rvalid !== 1'b1);
      rd = o_rdata;
      rsp = o_rresp;
      i_rready <= 1'b0;
   endtask

   task wait_irq;
      int k;
      k = 0;
      while (o_irq !== 1'b1 && k < 50)
      begin
         @(posedge i_clk_sys);
         k++;
      end
   endtask

   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         stop_test();
      end
   end

   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      rd_reg(OFF_RAW_STATUS);
      chk(rd, RESET_ZERO);
      chk({o_irq, o_scl_hold_low, o_xfer_go}, 32'h0);
      rd_reg(8'h80);
      chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
      wr(OFF_RAW_STATUS, 32'hffff_ffff);
      chk(rsp, RESP_SLVERR);
      wr(OFF_MASK, 32'hffff_ffff);
      rd_reg(OFF_MASK);
      chk(rd, STATUS_USED);
      // Slave requests pending throughout, so gating is visible
      slv_wr <= 1'b1;
      slv_rd <= 1'b1;
      dly    <= 4'h9;
      wr(OFF_MASTER_CMD, 32'h0);
      @(posedge i_clk_sys);
      chk({o_xfer_go, o_send_stop}, 32'h2);
      wait_irq();
      rd_reg(OFF_RAW_STATUS);
      chk(rd, 32'h1 << BIT_DONE_NO_STOP);
      chk({o_scl_hold_low, o_slave_wr_req, o_slave_rd_req}, 32'h4);
      wr(OFF_MASK, 32'h0);
      @(posedge i_clk_sys);
      chk(o_irq, 32'h0);
      wr(OFF_MASK, 32'hffff_ffff);
      rd_reg(OFF_MASKED);
      chk(rd, 32'h1 << BIT_DONE_NO_STOP);
      wr(OFF_MASTER_CMD, 32'h0);
      @(posedge i_clk_sys);
      chk(o_xfer_go, 32'h0);
      rd_reg(OFF_TRANS_STAT);
      chk(rd[3:0], TAG_NONE);
      wr(OFF_CLEAR, 32'h1 << BIT_DONE_NO_STOP);
      chk(rsp, RESP_OKAY);
      rd_reg(OFF_RAW_STATUS);
      chk(rd, RESET_ZERO);
      chk({o_scl_hold_low, o_slave_wr_req, o_slave_rd_req}, 32'h3);
      // Read with stop requested, partner answers sooner
      dly <= 4'h5;
      wr(OFF_MASTER_CMD, 32'h3);
      @(posedge i_clk_sys);
      chk({o_xfer_read, o_send_stop}, 32'h3);
      wait_irq();
      rd_reg(OFF_RAW_STATUS);
      chk(rd, 32'h1 << BIT_MASTER_DONE);
      wr(OFF_CLEAR, 32'h1 << BIT_MASTER_DONE);
      // Stray start in mid-transfer
      dly <= 4'h0;
      wr(OFF_MASTER_CMD, 32'h1);
      @(posedge i_clk_sys);
      inj_start <= 1'b1;
      @(posedge i_clk_sys);
      inj_start <= 1'b0;
      wait_irq();
      rd_reg(OFF_RAW_STATUS);
      chk(rd, 32'h1 << BIT_BUS_ERROR);
      rd_reg(OFF_TRANS_STAT);
      chk({o_xfer_go, rd[3:0]}, {1'b0, TAG_BUS_ERROR});
      wr(OFF_CLEAR, 32'h1 << BIT_BUS_ERROR);
      rd_reg(OFF_RAW_STATUS);
      chk(rd, RESET_ZERO);
      // Arbitration lost, then retry once the bus sees a stop
      wr(OFF_MASTER_CMD, 32'h1);
      @(posedge i_clk_sys);
      inj_arb <= 1'b1;
      @(posedge i_clk_sys);
      inj_arb <= 1'b0;
      wait_irq();
      rd_reg(OFF_TRANS_STAT);
      chk(rd & 32'h2f, 32'h20 | TAG_ARB_LOST);
      chk({o_abort_master, o_xfer_go}, 32'h2);
      wr(OFF_CLEAR, 32'h1 << BIT_ARB_LOST);
      rd_reg(OFF_RAW_STATUS);
      chk(rd, RESET_ZERO);
      dly <= 4'h2;
      inj_stop <= 1'b1;
      @(posedge i_clk_sys);
      inj_stop <= 1'b0;
      wait_irq();
      rd_reg(OFF_RAW_STATUS);
      chk(rd, 32'h1 << BIT_MASTER_DONE);
      chk(o_abort_master, 32'h0);
      wr(OFF_CLEAR, 32'h1 << BIT_MASTER_DONE);
      stop_test();
   end
endmodule
